// *** swc_defs.svh ***
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
`define SWC_IRQ_VECTOR 13'h0004
`define SWC_PC_W 13
`define SWC_PORT_W 8
`define SWC_CLKDIV 2'h3
`define SWC_PD_RESET 1'b1
`define SWC_TO_RESET 1'b1
`define SWC_FLAG_PD_BIT 3
`define SWC_FLAG_TO_BIT 4
`endif

// *** swc_pkg.sv ***
package swc_pkg;
  typedef enum logic [3:0]
  {
    SWC_RUN = 4'b0001,
    SWC_ENTER = 4'b0010,
    SWC_SLEEP = 4'b0100,
    SWC_WAKE = 4'b1000
  } swc_state_t;
  typedef logic [12:0] swc_pc_t;
endpackage

// *** swc_wake_if.sv ***
`timescale 1ns/100ps
interface swc_wake_if;
  logic ext_en;
  logic ext_flag;
  logic portb_en;
  logic portb_flag;
  logic timer_one_en;
  logic timer_one_flag;
  logic timer_one_async;
  logic adc_en;
  logic adc_flag;
  logic adc_rc_clk;
  logic pending;
  modport src (output ext_en, ext_flag, portb_en, portb_flag, timer_one_en, timer_one_flag,
    timer_one_async, adc_en, adc_flag, adc_rc_clk, input pending);
  modport eval (input ext_en, ext_flag, portb_en, portb_flag, timer_one_en, timer_one_flag,
    timer_one_async, adc_en, adc_flag, adc_rc_clk, output pending);
endinterface

// *** swc_wake_eval.sv ***
`timescale 1ns/100ps
module swc_wake_eval
  import swc_pkg::*;
(
  swc_wake_if.eval w
);
  function automatic logic src_hit(input logic en, input logic flag);
    src_hit = en & flag;
  endfunction
  // Only enabled sources; peripherals only in clockless-safe modes
  always_comb
  begin
    w.pending = src_hit(w.ext_en, w.ext_flag) | src_hit(w.portb_en, w.portb_flag)
      | (src_hit(w.timer_one_en, w.timer_one_flag) & w.timer_one_async)
      | (src_hit(w.adc_en, w.adc_flag) & w.adc_rc_clk);
  end
endmodule

// *** swc_top.sv ***
`timescale 1ns/100ps
`include "swc_defs.svh"
module swc_top
  import swc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sleep_instr_in,
  input wire logic [`SWC_PC_W-1:0] pc_in,
  input wire logic global_irq_enable_in,
  input wire logic master_clear_pin_n_in,
  input wire logic watchdog_timer_en_in,
  input wire logic watchdog_timer_timeout_in,
  input wire logic ext_irq_en_in,
  input wire logic ext_irq_flag_in,
  input wire logic portb_change_en_in,
  input wire logic portb_change_flag_in,
  input wire logic timer_one_en_in,
  input wire logic timer_one_flag_in,
  input wire logic timer_one_async_in,
  input wire logic adc_en_in,
  input wire logic adc_flag_in,
  input wire logic adc_rc_clk_in,
  input wire logic rc_mode_in,
  input wire logic [`SWC_PORT_W-1:0] port_out_val_in,
  input wire logic [`SWC_PORT_W-1:0] port_oe_in,
  output logic [`SWC_PORT_W-1:0] port_out_val_out,
  output logic [`SWC_PORT_W-1:0] port_oe_out,
  output logic power_down_flag_out,
  output logic timeout_flag_out,
  output logic watchdog_clear_out,
  output logic osc_driver_en_out,
  output logic phase_clk_en_out,
  output logic sleeping_out,
  output logic device_reset_out,
  output logic prefetch_out,
  output logic [`SWC_PC_W-1:0] prefetch_addr_out,
  output logic vector_out,
  output logic [`SWC_PC_W-1:0] vector_addr_out,
  output logic resume_out,
  output logic osc_output_pin_out
);
  swc_wake_if w();
  swc_wake_eval u_eval (.w(w));
  assign w.ext_en = ext_irq_en_in;
  assign w.ext_flag = ext_irq_flag_in;
  assign w.portb_en = portb_change_en_in;
  assign w.portb_flag = portb_change_flag_in;
  assign w.timer_one_en = timer_one_en_in;
  assign w.timer_one_flag = timer_one_flag_in;
  assign w.timer_one_async = timer_one_async_in;
  assign w.adc_en = adc_en_in;
  assign w.adc_flag = adc_flag_in;
  assign w.adc_rc_clk = adc_rc_clk_in;

  swc_state_t state_ff, nxt_state;
  logic pd_ff, nxt_pd, to_ff, nxt_to, wdc_ff, nxt_wdc, osc_ff, nxt_osc;
  logic rst_ff, nxt_rst, pf_ff, nxt_pf, vec_ff, nxt_vec, res_ff, nxt_res;
  logic gie_ff, nxt_gie, ck_ff, nxt_ck, slp_ff, nxt_slp;
  logic [`SWC_PC_W-1:0] va_ff, nxt_va;
  logic [1:0] div_ff, nxt_div;
  logic [`SWC_PC_W-1:0] pfa_ff, nxt_pfa;
  logic [`SWC_PORT_W-1:0] pv_ff, nxt_pv, po_ff, nxt_po;
  logic master_clear_pin;
  logic wdt_wake;
  assign master_clear_pin = ~master_clear_pin_n_in;
  assign wdt_wake = watchdog_timer_en_in & watchdog_timer_timeout_in;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_pd = pd_ff;
    nxt_to = to_ff;
    nxt_wdc = 1'b0;
    nxt_osc = osc_ff;
    nxt_rst = 1'b0;
    nxt_pf = 1'b0;
    nxt_pfa = pfa_ff;
    nxt_vec = 1'b0;
    nxt_res = 1'b0;
    nxt_gie = gie_ff;
    nxt_va = `SWC_IRQ_VECTOR;
    nxt_pv = pv_ff;
    nxt_po = po_ff;
    case (state_ff)
      SWC_RUN:
      begin
        nxt_pv = port_out_val_in;
        nxt_po = port_oe_in;
        if (sleep_instr_in && !master_clear_pin)
        begin
          nxt_pf = 1'b1;
          nxt_pfa = pc_in + `SWC_PC_W'(1);
          if (!w.pending)
          begin
            nxt_wdc = 1'b1;
            nxt_pd = 1'b0;
            nxt_to = 1'b1;
            nxt_osc = 1'b0;
            nxt_gie = global_irq_enable_in;
            nxt_state = SWC_ENTER;
          end
        end
      end
      SWC_ENTER:
      begin
        nxt_state = SWC_SLEEP;
        // Master clear during entry must not leave the device asleep
        if (master_clear_pin)
        begin
          nxt_state = SWC_RUN;
          nxt_osc = 1'b1;
        end
      end
      SWC_SLEEP:
      begin
        nxt_gie = global_irq_enable_in;
        if (master_clear_pin)
        begin
          nxt_state = SWC_RUN;
          nxt_rst = 1'b1;
          nxt_osc = 1'b1;
        end
        else if (wdt_wake || w.pending)
        begin
          if (wdt_wake && !w.pending)
          begin
            nxt_to = 1'b0;
          end
          nxt_osc = 1'b1;
          nxt_state = SWC_WAKE;
        end
      end
      SWC_WAKE:
      begin
        nxt_res = 1'b1;
        nxt_vec = gie_ff & w.pending;
        nxt_state = SWC_RUN;
      end
      default:
      begin
        nxt_state = SWC_RUN;
      end
    endcase
    if (master_clear_pin && state_ff != SWC_SLEEP)
    begin
      nxt_rst = 1'b1;
    end
    nxt_slp = ~nxt_osc;
  end

  // Clock-out divider runs only while the oscillator is driven
  always_comb
  begin
    nxt_div = div_ff;
    nxt_ck = ck_ff;
    if (rc_mode_in && osc_ff)
    begin
      nxt_div = div_ff + 2'h1;
      nxt_ck = (div_ff == `SWC_CLKDIV) ? ~ck_ff : ck_ff;
      if (div_ff[0])
      begin
        nxt_ck = ~ck_ff;
      end
    end
    else if (!rc_mode_in)
    begin
      nxt_ck = 1'b0;
      nxt_div = 2'h0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= SWC_RUN;
      pd_ff <= `SWC_PD_RESET;
      to_ff <= `SWC_TO_RESET;
      wdc_ff <= 1'b0;
      osc_ff <= 1'b1;
      rst_ff <= 1'b0;
      pf_ff <= 1'b0;
      pfa_ff <= '0;
      vec_ff <= 1'b0;
      res_ff <= 1'b0;
      gie_ff <= 1'b0;
      slp_ff <= 1'b0;
      va_ff <= `SWC_IRQ_VECTOR;
      pv_ff <= '0;
      po_ff <= '0;
      div_ff <= 2'h0;
      ck_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pd_ff <= nxt_pd;
      to_ff <= nxt_to;
      wdc_ff <= nxt_wdc;
      osc_ff <= nxt_osc;
      rst_ff <= nxt_rst;
      pf_ff <= nxt_pf;
      pfa_ff <= nxt_pfa;
      vec_ff <= nxt_vec;
      res_ff <= nxt_res;
      gie_ff <= nxt_gie;
      slp_ff <= nxt_slp;
      va_ff <= nxt_va;
      pv_ff <= nxt_pv;
      po_ff <= nxt_po;
      div_ff <= nxt_div;
      ck_ff <= nxt_ck;
    end
  end

  assign port_out_val_out = pv_ff;
  assign port_oe_out = po_ff;
  assign power_down_flag_out = pd_ff;
  assign timeout_flag_out = to_ff;
  assign watchdog_clear_out = wdc_ff;
  assign osc_driver_en_out = osc_ff;
  assign phase_clk_en_out = osc_ff;
  assign sleeping_out = slp_ff;
  assign device_reset_out = rst_ff;
  assign prefetch_out = pf_ff;
  assign prefetch_addr_out = pfa_ff;
  assign vector_out = vec_ff;
  assign vector_addr_out = va_ff;
  assign resume_out = res_ff;
  assign osc_output_pin_out = ck_ff;

  sleep_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_RUN && sleep_instr_in && !master_clear_pin && !w.pending)
    |=> (wdc_ff && !pd_ff && to_ff && !osc_ff))
    else $error("sleep entry flags wrong");
  nop_sleep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_RUN && sleep_instr_in && !master_clear_pin && w.pending)
    |=> (!wdc_ff && $stable(pd_ff) && $stable(to_ff) && osc_ff))
    else $error("pending sleep not a no-op");
  prefetch_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_RUN && sleep_instr_in && !master_clear_pin)
    |=> (pf_ff && pfa_ff == $past(pc_in) + 13'h0001))
    else $error("prefetch address wrong");
  master_clear_pin_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_SLEEP && master_clear_pin) |=> (rst_ff && osc_ff && !res_ff))
    else $error("master clear did not reset");
  wdt_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_SLEEP && !master_clear_pin && wdt_wake && !w.pending) |=> !to_ff)
    else $error("timeout flag not cleared");
  sequence wake_seq;
    state_ff == SWC_SLEEP && !master_clear_pin && w.pending;
  endsequence
  irq_resume_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wake_seq |=> osc_ff ##1 res_ff)
    else $error("interrupt wake did not resume");
  ports_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_SLEEP) |=> $stable(port_oe_out) && $stable(port_out_val_out))
    else $error("ports changed in sleep");
  stay_asleep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == SWC_SLEEP && !master_clear_pin && !wdt_wake && !w.pending) |=> !osc_ff)
    else $error("spurious wake");
  pd_only_sleep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(pd_ff) |-> $past(sleep_instr_in))
    else $error("power-down flag cleared without sleep");
endmodule

// *** swc_core_model.sv ***
`timescale 1ns/100ps
module swc_core_model
  import swc_pkg::*;
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire swc_pc_t pc_in,
  input wire logic resume_in,
  output logic sleep_instr_out,
  output swc_pc_t pc_out,
  output int resumes_out
);
  initial
  begin
    sleep_instr_out = 1'b0;
    pc_out = '0;
    resumes_out = 0;
  end
  // One-cycle sleep issue, never repeated back to back
  always @(posedge clk_in)
  begin
    sleep_instr_out <= go_in && !sleep_instr_out;
    pc_out <= pc_in;
    if (resume_in)
    begin
      resumes_out <= resumes_out + 1;
    end
  end
endmodule

// *** swc_top_tb.sv ***
`timescale 1ns/100ps
`include "swc_defs.svh"
module swc_top_tb;
  logic clk_in = 1'b0, rst_in = 1'b1, go, global_irq_enable, master_clear_pin_n, wen, wto, rc;
  logic ext_en, ext_f, pb_en, pb_f, t1_en, t1_f, t1_as, ad_en, ad_f, ad_rc;
  logic [`SWC_PC_W-1:0] pc, core_pc, pf_addr, vec_addr;
  logic [`SWC_PORT_W-1:0] pv, poe, pv_o, poe_o;
  logic sleep_i, pd, to, wdc, osc, ph, slp, drst, pf, vec, res, ck;
  int resumes, num_errors = 0, n_tests = 0;
  always #5 clk_in = ~clk_in;
  swc_core_model core (.clk_in(clk_in), .go_in(go), .pc_in(pc), .resume_in(res),
    .sleep_instr_out(sleep_i), .pc_out(core_pc), .resumes_out(resumes));
  swc_top dut (.clk_in(clk_in), .rst_in(rst_in), .sleep_instr_in(sleep_i), .pc_in(core_pc),
    .global_irq_enable_in(global_irq_enable), .master_clear_pin_n_in(master_clear_pin_n), .watchdog_timer_en_in(wen),
    .watchdog_timer_timeout_in(wto), .ext_irq_en_in(ext_en), .ext_irq_flag_in(ext_f),
    .portb_change_en_in(pb_en), .portb_change_flag_in(pb_f), .timer_one_en_in(t1_en),
    .timer_one_flag_in(t1_f), .timer_one_async_in(t1_as), .adc_en_in(ad_en),
    .adc_flag_in(ad_f), .adc_rc_clk_in(ad_rc), .rc_mode_in(rc), .port_out_val_in(pv),
    .port_oe_in(poe), .port_out_val_out(pv_o), .port_oe_out(poe_o),
    .power_down_flag_out(pd), .timeout_flag_out(to), .watchdog_clear_out(wdc),
    .osc_driver_en_out(osc), .phase_clk_en_out(ph), .sleeping_out(slp),
    .device_reset_out(drst), .prefetch_out(pf), .prefetch_addr_out(pf_addr),
    .vector_out(vec), .vector_addr_out(vec_addr), .resume_out(res),
    .osc_output_pin_out(ck));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Bounded wait for resume (0) or device reset (1)
  task automatic wait_for(input int sel);
    int k = 0;
    while (((sel == 0) ? res : drst) !== 1'b1 && k < 20)
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (k == 20)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic do_reset;
    rst_in <= 1'b1;
    cyc(2);
    rst_in <= 1'b0;
    cyc(1);
    #1;
    chk("pd_reset", 1'b1, pd);
    chk("to_reset", 1'b1, to);
    chk("osc_reset", 1'b1, osc);
  endtask
  // Caller stands on a rising edge
  task automatic enter_sleep(input logic [12:0] a);
    logic [12:0] nxt = a + 13'h1;
    go <= 1'b1;
    pc <= a;
    cyc(1);
    go <= 1'b0;
    cyc(1);
    #1;
    chk("prefetch", 1'b1, pf);
    chk("prefetch_addr", nxt, pf_addr);
  endtask
  task automatic t_irq;
    cyc(1);
    global_irq_enable <= 1'b1;
    ext_en <= 1'b1;
    pv <= 8'hA5;
    poe <= 8'h0F;
    cyc(2);
    enter_sleep(13'h0100);
    chk("wdt_clear", 1'b1, wdc);
    chk("pd_sleep", 1'b0, pd);
    chk("to_sleep", 1'b1, to);
    chk("osc_off", 1'b0, osc);
    cyc(1);
    pv <= 8'h5A;
    poe <= 8'hF0;
    cyc(3);
    #1;
    chk("port_val", 8'hA5, pv_o);
    chk("port_oe", 8'h0F, poe_o);
    chk("asleep", 1'b1, slp);
    cyc(1);
    ext_f <= 1'b1;
    wait_for(0);
    chk("vector", 1'b1, vec);
    chk("vector_addr", `SWC_IRQ_VECTOR, vec_addr);
    chk("phase_on", 1'b1, ph);
    cyc(1);
    ext_f <= 1'b0;
    global_irq_enable <= 1'b0;
    $display("Test irq wake done");
  endtask
  task automatic t_wdt;
    cyc(1);
    wen <= 1'b1;
    enter_sleep(13'h0200);
    cyc(2);
    wto <= 1'b1;
    wait_for(0);
    chk("to_wdt", 1'b0, to);
    chk("no_vector", 1'b0, vec);
    cyc(1);
    wto <= 1'b0;
    #1;
    chk("resumes", 16'h0002, resumes[15:0]);
    $display("Test watchdog wake done");
  endtask
  task automatic t_master_clear_pin;
    cyc(1);
    enter_sleep(13'h0300);
    cyc(2);
    master_clear_pin_n <= 1'b0;
    wait_for(1);
    chk("no_resume", 1'b0, res);
    chk("osc_back", 1'b1, osc);
    cyc(1);
    master_clear_pin_n <= 1'b1;
    $display("Test master clear done");
  endtask
  task automatic t_noop;
    do_reset();
    cyc(1);
    ext_en <= 1'b1;
    ext_f <= 1'b1;
    enter_sleep(13'h0400);
    chk("noop_wdc", 1'b0, wdc);
    chk("noop_pd", 1'b1, pd);
    chk("noop_osc", 1'b1, osc);
    cyc(1);
    ext_f <= 1'b0;
    $display("Test pending noop done");
  endtask
  task automatic t_gate(input int src);
    cyc(1);
    pb_en <= src != 0;
    t1_en <= 1'b1;
    ad_en <= 1'b1;
    enter_sleep(13'h1FFF);
    cyc(2);
    case (src)
      0: pb_f <= 1'b1;
      1: t1_f <= 1'b1;
      default: ad_f <= 1'b1;
    endcase
    cyc(6);
    #1;
    chk("gated_sleep", 1'b1, slp);
    cyc(1);
    case (src)
      0: pb_en <= 1'b1;
      1: t1_as <= 1'b1;
      default: ad_rc <= 1'b1;
    endcase
    wait_for(0);
    chk("gate_vector", 1'b0, vec);
    cyc(1);
    {pb_f, t1_f, ad_f, pb_en, t1_as, ad_rc} <= 6'h00;
    $display("Test gate %0d done", src);
  endtask
  task automatic t_clkout;
    int edges = 0;
    logic last;
    cyc(1);
    rc <= 1'b1;
    cyc(2);
    #1;
    last = ck;
    repeat (8)
    begin
      @(posedge clk_in);
      #1;
      edges += (ck !== last);
      last = ck;
    end
    chk("clkout_edges", 16'h0004, edges[15:0]);
    $display("Test clock out done");
  endtask
  initial
  begin
    {go, global_irq_enable, wen, wto, rc, ext_en, ext_f, pb_en, pb_f} = 9'h000;
    {t1_en, t1_f, t1_as, ad_en, ad_f, ad_rc} = 6'h00;
    master_clear_pin_n = 1'b1;
    pc = '0;
    pv = '0;
    poe = '0;
    do_reset();
    t_clkout();
    t_irq();
    t_wdt();
    t_master_clear_pin();
    t_noop();
    for (int s = 0; s < 3; s++)
      t_gate(s);
    stop_test();
  end
endmodule
